// file: ilc_pkg.sv
// Shared constants for the interrupt level and detection slice
package ilc_pkg;

    // Register port geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Sources handled by this slice, and the width of a level code
    localparam int NSRC = 6;
    localparam int LVL_W = 3;
    localparam int NUM_W = 5;
    localparam int IDX_W = 3;
    localparam int DET_W = 2;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_DETECT = 16'hf608;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL = 16'hf610;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'hf680;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = 16'hf684;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 16'hf688;

    // Field positions inside the detection-mode register
    localparam int SER1_DET_LSB = 2;
    localparam int SER0_DET_LSB = 0;

    // Field positions inside the level register
    localparam int TIMER0_LVL_LSB = 24;
    localparam int PCI0_LVL_LSB = 16;
    localparam int WTO_LVL_LSB = 8;
    localparam int ECC_LVL_LSB = 0;

    // Writable bits; everything else is reserved and reads zero
    localparam logic [DATA_W-1:0] LEVEL_MASK = 32'h07070707;
    localparam logic [DATA_W-1:0] DETECT_MASK = 32'h0000000f;

    // Reset values and special codes
    localparam logic [DATA_W-1:0] LEVEL_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] DETECT_RESET = 32'h00000000;
    localparam logic [DET_W-1:0] DET_LOW_ACTIVE = 2'h0;
    localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
    localparam logic [LVL_W-1:0] SERIAL_LEVEL = 3'h1;
    localparam logic [NSRC-1:0] FLAGS_RESET = 6'h00;

    // Source slots, lowest slot wins a tie between equal levels
    typedef enum logic [IDX_W-1:0] {
        SRC_ECC,
        SRC_WTO,
        SRC_PCI0,
        SRC_TIMER0,
        SRC_SER0,
        SRC_SER1
    } ilc_src_e;

    // Interrupt input numbers per slot, slot 5 in the top field
    localparam logic [NSRC*NUM_W-1:0] INT_NUM_TABLE =
        {5'h09, 5'h08, 5'h11, 5'h10, 5'h01, 5'h00};
    localparam logic [NUM_W-1:0] INT_NUM_TIMER0 = 5'h11;
    localparam logic [NUM_W-1:0] INT_NUM_PCI0 = 5'h10;
    localparam logic [NUM_W-1:0] INT_NUM_WTO = 5'h01;
    localparam logic [NUM_W-1:0] INT_NUM_ECC = 5'h00;

endpackage : ilc_pkg

// file: ilc_prio_pick.sv
`timescale 1ns/1ps
// Picks the highest-level active source and registers the winner
module ilc_prio_pick (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ilc_pkg::NSRC-1:0] src_active,
    input wire logic [ilc_pkg::NSRC*ilc_pkg::LVL_W-1:0] src_level,
    output logic win_req,
    output logic [ilc_pkg::LVL_W-1:0] win_level,
    output logic [ilc_pkg::IDX_W-1:0] win_idx
);
    import ilc_pkg::*;

    logic next_req;
    logic [LVL_W-1:0] next_level;
    logic [IDX_W-1:0] next_idx;

    // Linear scan; strict compare keeps the lowest slot on a tie
    always_comb begin
        next_req = 1'b0;
        next_level = LVL_OFF;
        next_idx = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (src_active[i] &&
                src_level[i*LVL_W +: LVL_W] > next_level) begin
                next_req = 1'b1;
                next_level = src_level[i*LVL_W +: LVL_W];
                next_idx = IDX_W'(i);
            end
        end
    end

    // Winner held in flops so the core sees glitch-free data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            win_req <= 1'b0;
            win_level <= LVL_OFF;
            win_idx <= '0;
        end else begin
            win_req <= next_req;
            win_level <= next_level;
            win_idx <= next_idx;
        end
    end

endmodule : ilc_prio_pick

// file: ilc_ctrl.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Serial port 1 detect code bits 3:2; 00 low active, else disabled.
// - Serial port 0 detect code bits 1:0; 00 low active, else disabled.
// - Level bits 26:24 set timer 0 priority (input 17), reset 000.
// - Level bits 18:16 set PCI controller 0 priority (input 16).
// - Level bits 10:8 set write timeout error priority (input 1).
// - Level bits 2:0 set ECC error priority (input 0).
// - Code n gives level n; code 000 disables the source.
// - Level fields are read/write and reset to 000, all disabled.
module ilc_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ilc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ilc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ilc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic serial0_req_n,
    input wire logic serial1_req_n,
    input wire logic timer0_req,
    input wire logic pci0_req,
    input wire logic write_timeout_req,
    input wire logic ecc_error_req,
    output logic core_int_req,
    output logic [ilc_pkg::LVL_W-1:0] core_int_level,
    output logic [ilc_pkg::NUM_W-1:0] core_int_num,
    output logic irq
);
    import ilc_pkg::*;

    // Software-visible state
    logic [DATA_W-1:0] interrupt_level_bank0;
    logic [DATA_W-1:0] interrupt_detect_mode_bank1;
    logic [NSRC-1:0] int_status;
    logic [NSRC-1:0] int_enable;

    // Qualified source state
    logic [NSRC-1:0] prev_active;
    wire [NSRC-1:0] src_raw;
    wire [NSRC-1:0] src_enabled;
    wire [NSRC-1:0] src_active;
    wire [NSRC-1:0] src_rise;
    wire [NSRC*LVL_W-1:0] src_level;

    // Named fields
    wire [DET_W-1:0] serial1_detect_code;
    wire [DET_W-1:0] serial0_detect_code;
    wire [LVL_W-1:0] timer0_prio_level;
    wire [LVL_W-1:0] pci0_prio_level;
    wire [LVL_W-1:0] write_timeout_prio_level;
    wire [LVL_W-1:0] ecc_error_prio_level;

    // Address decode
    wire hit_detect;
    wire hit_level;
    wire hit_status;
    wire hit_clear;
    wire hit_enable;
    wire wr_detect;
    wire wr_level;
    wire wr_clear;
    wire wr_enable;
    wire [DATA_W-1:0] rd_mux;
    wire [NSRC-1:0] clr_bits;
    wire [NSRC-1:0] next_status;
    wire [NSRC-1:0] next_enable;

    // Picker result
    wire pick_req;
    wire [LVL_W-1:0] pick_level;
    wire [IDX_W-1:0] pick_idx;

    // Field extraction from the two configuration words
    assign serial1_detect_code =
        interrupt_detect_mode_bank1[SER1_DET_LSB +: DET_W];
    assign serial0_detect_code =
        interrupt_detect_mode_bank1[SER0_DET_LSB +: DET_W];
    assign timer0_prio_level =
        interrupt_level_bank0[TIMER0_LVL_LSB +: LVL_W];
    assign pci0_prio_level =
        interrupt_level_bank0[PCI0_LVL_LSB +: LVL_W];
    assign write_timeout_prio_level =
        interrupt_level_bank0[WTO_LVL_LSB +: LVL_W];
    assign ecc_error_prio_level =
        interrupt_level_bank0[ECC_LVL_LSB +: LVL_W];

    // Raw requests in slot order; serial lines are active low
    assign src_raw = {~serial1_req_n, ~serial0_req_n, timer0_req,
                      pci0_req, write_timeout_req, ecc_error_req};

    // Level per slot; serial ports have no level field in this slice
    assign src_level = {SERIAL_LEVEL, SERIAL_LEVEL, timer0_prio_level,
                        pci0_prio_level, write_timeout_prio_level,
                        ecc_error_prio_level};

    // Enable terms: level 000 or a non-zero detect code blocks a slot
    assign src_enabled[SRC_ECC] = ecc_error_prio_level != LVL_OFF;
    assign src_enabled[SRC_WTO] =
        write_timeout_prio_level != LVL_OFF;
    assign src_enabled[SRC_PCI0] = pci0_prio_level != LVL_OFF;
    assign src_enabled[SRC_TIMER0] = timer0_prio_level != LVL_OFF;
    assign src_enabled[SRC_SER0] =
        serial0_detect_code == DET_LOW_ACTIVE;
    assign src_enabled[SRC_SER1] =
        serial1_detect_code == DET_LOW_ACTIVE;

    // Per-slot gating and edge detection for the sticky status
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign src_active[gi] = src_raw[gi] & src_enabled[gi];
            assign src_rise[gi] = src_active[gi] & ~prev_active[gi];
        end
    endgenerate

    // Register decode, one aligned word per register
    assign hit_detect = reg_addr == ADDR_DETECT;
    assign hit_level = reg_addr == ADDR_LEVEL;
    assign hit_status = reg_addr == ADDR_STATUS;
    assign hit_clear = reg_addr == ADDR_CLEAR;
    assign hit_enable = reg_addr == ADDR_ENABLE;
    assign wr_detect = reg_wr & hit_detect;
    assign wr_level = reg_wr & hit_level;
    assign wr_clear = reg_wr & hit_clear;
    assign wr_enable = reg_wr & hit_enable;

    // Read selection; clear register and unmapped words read zero
    assign rd_mux = hit_detect ? interrupt_detect_mode_bank1 :
                    hit_level ? interrupt_level_bank0 :
                    hit_status ? DATA_W'(int_status) :
                    hit_enable ? DATA_W'(int_enable) :
                    '0;

    // A new event in the clearing cycle survives: set beats clear
    assign clr_bits = wr_clear ? reg_wdata[NSRC-1:0] : '0;
    assign next_status = (int_status & ~clr_bits) | src_rise;

    // Enable as it stands after this edge, so irq never lags a write
    assign next_enable = wr_enable ? reg_wdata[NSRC-1:0] : int_enable;

    // Configuration registers; reserved bits never get stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_level_bank0 <= LEVEL_RESET;
            interrupt_detect_mode_bank1 <= DETECT_RESET;
        end else begin
            if (wr_level) begin
                interrupt_level_bank0 <= reg_wdata & LEVEL_MASK;
            end
            if (wr_detect) begin
                interrupt_detect_mode_bank1 <= reg_wdata & DETECT_MASK;
            end
        end
    end

    // Status, enable and edge history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_status <= FLAGS_RESET;
            int_enable <= FLAGS_RESET;
            prev_active <= FLAGS_RESET;
        end else begin
            int_status <= next_status;
            prev_active <= src_active;
            int_enable <= next_enable;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // Level interrupt, high while any enabled status bit is set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_enable);
        end
    end

    // Highest-level pick, registered inside the picker
    ilc_prio_pick u_pick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_active(src_active),
        .src_level(src_level),
        .win_req(pick_req),
        .win_level(pick_level),
        .win_idx(pick_idx)
    );

    // Translate the winning slot to its interrupt input number
    assign core_int_req = pick_req;
    assign core_int_level = pick_level;
    assign core_int_num = pick_req ?
        INT_NUM_TABLE[pick_idx*NUM_W +: NUM_W] : '0;

    // Checks on the block's own outputs and state
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // A disabled serial port never becomes active
    a_ser1_code_gate: assert property (
        serial1_detect_code != DET_LOW_ACTIVE |-> !src_active[SRC_SER1])
        else $error("serial port 1 active while its code disables it");

    a_ser0_code_gate: assert property (
        (serial0_detect_code == DET_LOW_ACTIVE && !serial0_req_n)
        == src_active[SRC_SER0])
        else $error("serial port 0 activity does not follow its code");

    // Forwarded level of each documented source matches its field
    a_timer0_level_fwd: assert property (
        core_int_req && core_int_num == INT_NUM_TIMER0
        |-> core_int_level == $past(timer0_prio_level) &&
            $past(timer0_req))
        else $error("timer 0 forwarded with wrong level");

    a_pci0_level_fwd: assert property (
        core_int_req && core_int_num == INT_NUM_PCI0
        |-> core_int_level == $past(pci0_prio_level) && $past(pci0_req))
        else $error("PCI 0 forwarded with wrong level");

    a_wto_level_fwd: assert property (
        core_int_req && core_int_num == INT_NUM_WTO
        |-> core_int_level == $past(write_timeout_prio_level) &&
            $past(write_timeout_req))
        else $error("write timeout forwarded with wrong level");

    a_ecc_level_fwd: assert property (
        core_int_req && core_int_num == INT_NUM_ECC
        |-> core_int_level == $past(ecc_error_prio_level) &&
            $past(ecc_error_req))
        else $error("ECC error forwarded with wrong level");

    // Level zero never reaches the core
    a_no_level_zero: assert property (
        core_int_req |-> core_int_level != LVL_OFF)
        else $error("request forwarded at level zero");

    // A level write followed by a read returns the masked word
    sequence s_level_write;
        wr_level;
    endsequence

    sequence s_level_read;
        reg_rd && hit_level;
    endsequence

    a_level_readback: assert property (
        s_level_write ##1 s_level_read
        |=> reg_rdata == ($past(reg_wdata, 2) & LEVEL_MASK))
        else $error("level register readback mismatch");

    a_reserved_zero: assert property (
        s_level_read |=> (reg_rdata & ~LEVEL_MASK) == '0)
        else $error("reserved level bits read non-zero");

    // Reserved detect bits read zero as well
    a_detect_resv_zero: assert property (
        reg_rd && hit_detect |=> (reg_rdata & ~DETECT_MASK) == '0)
        else $error("reserved detect bits read non-zero");

    // Read data never lingers past its one cycle
    a_rdata_one_cycle: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data stands longer than one cycle");

    // A cleared status bit with no new event stays clear
    a_clear_works: assert property (
        wr_clear && (src_rise & reg_wdata[NSRC-1:0]) == '0
        |=> (int_status & $past(reg_wdata[NSRC-1:0])) == '0)
        else $error("status clear lost");

    // Request follows any active source one cycle later
    a_request_follows: assert property (
        core_int_req == $past(|src_active))
        else $error("core request does not follow active sources");

    // An active timer 0 may not carry a higher level than the winner
    a_highest_wins: assert property (
        $past(src_active[SRC_TIMER0]) |->
            core_int_level >= $past(timer0_prio_level))
        else $error("a higher-level source lost arbitration");

    // A rising source is recorded even when cleared that cycle
    a_status_sticky: assert property (
        src_rise != '0 |=> (int_status & $past(src_rise)) ==
            $past(src_rise))
        else $error("status event lost");

    // Interrupt line tracks enabled status
    a_irq_line: assert property (
        irq == |(int_status & int_enable))
        else $error("irq does not match enabled status");

endmodule : ilc_ctrl

// file: ilc_src_model.sv
`timescale 1ns/1ps
// Peripheral request lines as the controller sees them at its inputs
module ilc_src_model (
    input wire logic rst_n,
    input wire logic [ilc_pkg::NSRC-1:0] want,
    output logic serial0_req_n,
    output logic serial1_req_n,
    output logic timer0_req,
    output logic pci0_req,
    output logic write_timeout_req,
    output logic ecc_error_req
);
    import ilc_pkg::*;

    // Serial ports signal active low; in reset every line sits idle
    assign serial0_req_n = ~(rst_n & want[SRC_SER0]);
    assign serial1_req_n = ~(rst_n & want[SRC_SER1]);
    // The other sources raise a high level and hold it while their want bit is set
    assign timer0_req = rst_n & want[SRC_TIMER0];
    assign pci0_req = rst_n & want[SRC_PCI0];
    assign write_timeout_req = rst_n & want[SRC_WTO];
    assign ecc_error_req = rst_n & want[SRC_ECC];
endmodule : ilc_src_model

// file: irq_level_and_detect_config_tb.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    total_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD %s exp %h got %h", what, exp, got); \
    end

module irq_level_and_detect_config_tb;
    import ilc_pkg::*;
    logic sys_clk;
    logic rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic serial0_req_n;
    logic serial1_req_n;
    logic timer0_req;
    logic pci0_req;
    logic write_timeout_req;
    logic ecc_error_req;
    logic core_int_req;
    logic [LVL_W-1:0] core_int_level;
    logic [NUM_W-1:0] core_int_num;
    logic irq;
    logic [NSRC-1:0] want;
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] lv;
    logic [DATA_W-1:0] dt;
    logic [NSRC-1:0] en;
    logic exp_req;
    logic [LVL_W-1:0] exp_lvl;
    logic [NUM_W-1:0] exp_num;
    logic [NSRC-1:0] exp_act;
    int nums[NSRC] = '{0, 1, 16, 17, 8, 9};
    int errors;
    int total_checks;

    ilc_src_model ilc_src_model_i (.rst_n(rst_n), .want(want),
        .serial0_req_n(serial0_req_n), .serial1_req_n(serial1_req_n),
        .timer0_req(timer0_req), .pci0_req(pci0_req),
        .write_timeout_req(write_timeout_req),
        .ecc_error_req(ecc_error_req));

    ilc_ctrl ilc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial0_req_n(serial0_req_n), .serial1_req_n(serial1_req_n),
        .timer0_req(timer0_req), .pci0_req(pci0_req),
        .write_timeout_req(write_timeout_req),
        .ecc_error_req(ecc_error_req), .core_int_req(core_int_req),
        .core_int_level(core_int_level), .core_int_num(core_int_num),
        .irq(irq));

    // Verdict and end of run, shared by the main flow and the watchdog
    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // One-cycle write, then one idle cycle so strobes never double up
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = reg_rdata;
        @(posedge sys_clk);
    endtask : rd

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = reg_rdata;
        @(posedge sys_clk);
    endtask : wr_rd

    // Reference arbiter: level 0 or a non-zero detect code hides a source
    task automatic predict();
        int lvl[NSRC];
        int best;
        lvl[0] = lv[2:0];
        lvl[1] = lv[10:8];
        lvl[2] = lv[18:16];
        lvl[3] = lv[26:24];
        lvl[4] = (dt[1:0] == 2'h0) ? 1 : 0;
        lvl[5] = (dt[3:2] == 2'h0) ? 1 : 0;
        best = 0;
        exp_num = '0;
        for (int i = 0; i < NSRC; i++) begin
            exp_act[i] = want[i] && lvl[i] != 0;
            // Strict compare keeps the lowest slot on a tie
            if (exp_act[i] && lvl[i] > best) begin
                best = lvl[i];
                exp_num = NUM_W'(nums[i]);
            end
        end
        exp_lvl = LVL_W'(best);
        exp_req = best != 0;
    endtask : predict

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        #5000000;
        errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        want = '0;
        void'($urandom(93));
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Look mid-cycle, once the first edge after release has settled
        @(negedge sys_clk);
        `CHK("core_req_rst", 1'b0, core_int_req)
        `CHK("core_lvl_rst", LVL_OFF, core_int_level)
        `CHK("irq_rst", 1'b0, irq)
        @(posedge sys_clk);
        rd(ADDR_LEVEL);
        `CHK("level_rst", LEVEL_RESET, rd_val)
        rd(ADDR_DETECT);
        `CHK("detect_rst", DETECT_RESET, rd_val)
        // Unmapped place must read as zero
        rd(16'hf60c);
        `CHK("unmapped", 32'h00000000, rd_val)
        wr_rd(ADDR_LEVEL, 32'hffffffff);
        `CHK("level_resv", 32'h07070707, rd_val)
        // Random configurations and request patterns against the model
        for (int n = 0; n < 80; n++) begin
            want <= '0;
            wr(ADDR_CLEAR, 32'h0000003f);
            rd(ADDR_STATUS);
            `CHK("status_clr", 32'h00000000, rd_val)
            lv = $urandom();
            dt = $urandom();
            en = NSRC'($urandom());
            wr_rd(ADDR_LEVEL, lv);
            `CHK("level_b2b", lv & LEVEL_MASK, rd_val)
            wr(ADDR_DETECT, dt);
            wr(ADDR_ENABLE, {26'h0, en});
            rd(ADDR_LEVEL);
            `CHK("level", lv & 32'h07070707, rd_val)
            rd(ADDR_DETECT);
            `CHK("detect", dt & DETECT_MASK, rd_val)
            rd(ADDR_ENABLE);
            `CHK("enable", {26'h0, en}, rd_val)
            want <= NSRC'($urandom());
            @(posedge sys_clk);
            predict();
            @(negedge sys_clk);
            `CHK("core_req", exp_req, core_int_req)
            `CHK("core_level", exp_lvl, core_int_level)
            `CHK("core_num", exp_num, core_int_num)
            `CHK("irq", |(exp_act & en), irq)
            @(posedge sys_clk);
            rd(ADDR_STATUS);
            `CHK("status", {26'h0, exp_act}, rd_val)
        end
        wrap_up();
    end
endmodule : irq_level_and_detect_config_tb
